// ### pst_pkg.sv
package pst_pkg;

	// Field positions of the state word
	localparam int unsigned PST_IMPL_LSB = 28;
	localparam int unsigned PST_VER_LSB = 24;
	localparam int unsigned PST_N_BIT = 23;
	localparam int unsigned PST_Z_BIT = 22;
	localparam int unsigned PST_V_BIT = 21;
	localparam int unsigned PST_C_BIT = 20;
	localparam int unsigned PST_CPE_BIT = 13;
	localparam int unsigned PST_FPE_BIT = 12;
	localparam int unsigned PST_PIL_LSB = 8;
	localparam int unsigned PST_S_BIT = 7;
	localparam int unsigned PST_PS_BIT = 6;
	localparam int unsigned PST_ET_BIT = 5;
	localparam int unsigned PST_CWP_LSB = 0;

	// Field widths and default window count
	localparam int unsigned PST_ID_W = 4;
	localparam int unsigned PST_PIL_W = 4;
	localparam int unsigned PST_CWP_FIELD_W = 5;
	localparam int unsigned PST_NWIN_DEF = 8;

	// Interrupt level that ignores the level field, and the no-request level
	localparam logic [3:0] PST_NMI_LEVEL = 4'hF;
	localparam logic [3:0] PST_NO_IRQ = 4'h0;

	// Reset values
	localparam logic PST_S_RST = 1'b1;
	localparam logic PST_ET_RST = 1'b0;
	localparam logic [3:0] PST_ICC_RST = 4'h0;
	localparam logic [3:0] PST_PIL_RST = 4'h0;
	localparam logic PST_EN_RST = 1'b0;

	// Identification fields, values arbitrary
	localparam logic [3:0] PST_IMPL_DEF = 4'hA;
	localparam logic [3:0] PST_VER_DEF = 4'h5;

	// Operation kinds for condition-code generation
	typedef enum logic [1:0] {
		PST_OP_ADD = 2'b00,
		PST_OP_SUB = 2'b01,
		PST_OP_LOGIC = 2'b11
	} pst_op_t;

	// Run state of the unit
	typedef enum logic {
		PST_RUN = 1'b0,
		PST_ERROR = 1'b1
	} pst_mode_t;

endpackage : pst_pkg

// ### pst_icc_calc.sv
`timescale 1ns/1ps
`default_nettype none
module pst_icc_calc
	import pst_pkg::*;
(
	input wire logic [31:0] i_op_a,
	input wire logic [31:0] i_op_b,
	input wire pst_op_t i_op,
	input wire logic [31:0] i_logic_res,
	output logic [31:0] o_result,
	output logic o_n,
	output logic o_z,
	output logic o_v,
	output logic o_c
);
	logic [32:0] sum;
	logic [32:0] diff;
	logic ovf_add;
	logic ovf_sub;

	assign sum = {1'b0, i_op_a} + {1'b0, i_op_b};
	assign diff = {1'b0, i_op_a} - {1'b0, i_op_b};
	assign ovf_add = (i_op_a[31] == i_op_b[31]) && (sum[31] != i_op_a[31]);
	assign ovf_sub = (i_op_a[31] != i_op_b[31]) && (diff[31] != i_op_a[31]);

	assign o_result = (i_op == PST_OP_ADD) ? sum[31:0] :
		(i_op == PST_OP_SUB) ? diff[31:0] : i_logic_res;
	assign o_n = o_result[31];
	assign o_z = (o_result == 32'h0000_0000);
	assign o_v = (i_op == PST_OP_ADD) ? ovf_add : (i_op == PST_OP_SUB) ? ovf_sub : 1'b0;
	// carry or borrow at bit 31
	assign o_c = (i_op == PST_OP_ADD) ? sum[32] : (i_op == PST_OP_SUB) ? diff[32] : 1'b0;
endmodule : pst_icc_calc
`default_nettype wire

// ### pst_state_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Negative flag follows result sign
// - Zero flag set for zero result
// - Overflow flag on unrepresentable result
// - Carry on add carry, subtract borrow
// - Coprocessor enable stored, instructions always trap
// - Float instructions trap while enable clear
// - Accept interrupt above level field
// - Level fifteen ignores level field
// - Supervisor bit selects privilege mode
// - Trap copies supervisor into prior supervisor
// - Trap clears trap enable bit
// - Traps off: ignore interrupts, exceptions halt
// - Window pointer moves modulo window count
// - Read-only implementation and version fields
// - Writes to read-only fields ignored
// - Access only by privileged read/write
module pst_state_reg
	import pst_pkg::*;
#(
	parameter int unsigned NWIN = PST_NWIN_DEF,
	parameter logic [3:0] IMPL_ID = PST_IMPL_DEF,
	parameter logic [3:0] VER_ID = PST_VER_DEF
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_cc_en,
	input wire pst_op_t i_op,
	input wire logic [31:0] i_op_a,
	input wire logic [31:0] i_op_b,
	input wire logic [31:0] i_logic_res,
	input wire logic i_exc_req,
	input wire logic [3:0] i_irq_level,
	input wire logic i_fp_instr,
	input wire logic i_cp_instr,
	input wire logic i_save,
	input wire logic i_restore,
	input wire logic i_rett,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [31:0] i_wr_data,
	output logic [31:0] o_rd_data,
	output logic [31:0] o_state,
	output logic o_supervisor,
	output logic o_trap_take,
	output logic o_irq_take,
	output logic o_fp_trap,
	output logic o_cp_trap,
	output logic o_priv_trap,
	output logic o_error_mode
);
	localparam int unsigned CWP_W = (NWIN <= 2) ? 1 : $clog2(NWIN);

	// Window count must fit the five-bit field and wrap by plain overflow
	if (NWIN < 2 || NWIN > 32 || (NWIN & (NWIN - 1)) != 0) begin : g_bad_nwin
		$error("NWIN must be a power of two from 2 to 32");
	end

	function automatic logic [CWP_W-1:0] cwp_step(input logic [CWP_W-1:0] cur, input logic up);
		cwp_step = up ? cur + 1'b1 : cur - 1'b1;
	endfunction : cwp_step

	logic n_q, n_d;
	logic z_q, z_d;
	logic v_q, v_d;
	logic c_q, c_d;
	logic cpe_q, cpe_d;
	logic fpe_q, fpe_d;
	logic [3:0] pil_q, pil_d;
	logic s_q, s_d;
	logic ps_q, ps_d;
	logic et_q, et_d;
	logic [CWP_W-1:0] cwp_q, cwp_d;
	logic [31:0] rd_q, rd_d;
	pst_mode_t mode_q, mode_d;

	logic [31:0] alu_res;
	logic alu_n;
	logic alu_z;
	logic alu_v;
	logic alu_c;
	logic running;
	logic access;
	logic priv_bad;
	logic wr_ok;
	logic rd_ok;
	logic fp_bad;
	logic exc_any;
	logic irq_ok;
	logic trap_go;
	logic halt_go;
	logic [CWP_W-1:0] wr_cwp;
	logic [31:0] state_word;

	pst_icc_calc u_icc (
		.i_op_a(i_op_a),
		.i_op_b(i_op_b),
		.i_op(i_op),
		.i_logic_res(i_logic_res),
		.o_result(alu_res),
		.o_n(alu_n),
		.o_z(alu_z),
		.o_v(alu_v),
		.o_c(alu_c)
	);

	assign running = (mode_q == PST_RUN);
	assign access = i_rd_en || i_wr_en;
	assign priv_bad = access && !s_q;
	// only privileged access reaches the word
	assign wr_ok = i_wr_en && s_q;
	assign rd_ok = i_rd_en && s_q;
	assign fp_bad = i_fp_instr && !fpe_q;
	assign o_cp_trap = i_cp_instr;
	assign o_fp_trap = fp_bad;
	assign o_priv_trap = priv_bad;
	assign exc_any = i_exc_req || fp_bad || i_cp_instr || priv_bad;
	assign irq_ok = (i_irq_level != PST_NO_IRQ) &&
		((i_irq_level == PST_NMI_LEVEL) || (i_irq_level > pil_q));
	assign o_irq_take = running && et_q && irq_ok && !exc_any;
	assign trap_go = running && et_q && (exc_any || irq_ok);
	assign halt_go = running && !et_q && exc_any;
	assign o_trap_take = trap_go;
	assign wr_cwp = i_wr_data[PST_CWP_LSB +: CWP_W];

	always_comb begin
		state_word = 32'h0000_0000;
		state_word[PST_IMPL_LSB +: PST_ID_W] = IMPL_ID;
		state_word[PST_VER_LSB +: PST_ID_W] = VER_ID;
		state_word[PST_N_BIT] = n_q;
		state_word[PST_Z_BIT] = z_q;
		state_word[PST_V_BIT] = v_q;
		state_word[PST_C_BIT] = c_q;
		state_word[PST_CPE_BIT] = cpe_q;
		state_word[PST_FPE_BIT] = fpe_q;
		state_word[PST_PIL_LSB +: PST_PIL_W] = pil_q;
		state_word[PST_S_BIT] = s_q;
		state_word[PST_PS_BIT] = ps_q;
		state_word[PST_ET_BIT] = et_q;
		state_word[PST_CWP_LSB +: CWP_W] = cwp_q;
	end

	always_comb begin
		n_d = n_q;
		z_d = z_q;
		v_d = v_q;
		c_d = c_q;
		cpe_d = cpe_q;
		fpe_d = fpe_q;
		pil_d = pil_q;
		s_d = s_q;
		ps_d = ps_q;
		et_d = et_q;
		cwp_d = cwp_q;
		mode_d = mode_q;
		rd_d = rd_q;
		if (halt_go) begin
			mode_d = PST_ERROR;
		end else if (trap_go) begin
			ps_d = s_q;
			s_d = 1'b1;
			et_d = 1'b0;
			cwp_d = cwp_step(cwp_q, 1'b0);
		end else if (running && wr_ok) begin
			n_d = i_wr_data[PST_N_BIT];
			z_d = i_wr_data[PST_Z_BIT];
			v_d = i_wr_data[PST_V_BIT];
			c_d = i_wr_data[PST_C_BIT];
			cpe_d = i_wr_data[PST_CPE_BIT];
			fpe_d = i_wr_data[PST_FPE_BIT];
			pil_d = i_wr_data[PST_PIL_LSB +: PST_PIL_W];
			s_d = i_wr_data[PST_S_BIT];
			ps_d = i_wr_data[PST_PS_BIT];
			et_d = i_wr_data[PST_ET_BIT];
			cwp_d = wr_cwp;
		end else if (running) begin
			if (i_cc_en) begin
				n_d = alu_n;
				z_d = alu_z;
				v_d = alu_v;
				c_d = alu_c;
			end
			if (i_save) begin
				cwp_d = cwp_step(cwp_q, 1'b0);
			end else if (i_restore || i_rett) begin
				cwp_d = cwp_step(cwp_q, 1'b1);
			end
			if (i_rett) begin
				s_d = ps_q;
				et_d = 1'b1;
			end
		end
		// Read returns the word as it stood before this cycle
		if (running && rd_ok) begin
			rd_d = state_word;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_q <= PST_S_RST;
			et_q <= PST_ET_RST;
			ps_q <= PST_EN_RST;
			{n_q, z_q, v_q, c_q} <= PST_ICC_RST;
			cpe_q <= PST_EN_RST;
			fpe_q <= PST_EN_RST;
			pil_q <= PST_PIL_RST;
			cwp_q <= '0;
			mode_q <= PST_RUN;
			rd_q <= 32'h0000_0000;
		end else if (i_ce) begin
			{n_q, z_q, v_q, c_q} <= {n_d, z_d, v_d, c_d};
			cpe_q <= cpe_d;
			fpe_q <= fpe_d;
			pil_q <= pil_d;
			s_q <= s_d;
			ps_q <= ps_d;
			et_q <= et_d;
			cwp_q <= cwp_d;
			mode_q <= mode_d;
			rd_q <= rd_d;
		end
	end

	assign o_rd_data = rd_q;
	assign o_state = state_word;
	assign o_supervisor = s_q;
	assign o_error_mode = (mode_q == PST_ERROR);
endmodule : pst_state_reg
`default_nettype wire

// ### pst_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pst_monitor
	import pst_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_exc_req,
	input wire logic i_fp_instr,
	input wire logic i_cp_instr,
	input wire logic [3:0] i_irq_level,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [31:0] o_state,
	input wire logic o_supervisor,
	input wire logic o_priv_trap,
	input wire logic o_trap_take,
	input wire logic o_irq_take,
	input wire logic o_fp_trap,
	input wire logic o_cp_trap,
	input wire logic o_error_mode
);
	wire logic s = o_state[7];
	wire logic et = o_state[5];
	wire logic [2:0] cwp = o_state[2:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence trap_s;
		o_trap_take && i_ce;
	endsequence
	prev_sup_a: assert property (trap_s |=> o_state[6] == $past(s))
		else $error("prior supervisor bad");
	trap_off_a: assert property (trap_s |=> !et && s)
		else $error("trap enable not cleared");
	win_dec_a: assert property (trap_s |=> cwp == $past(cwp) - 3'h1)
		else $error("window pointer bad");
	halt_enter_a: assert property (i_ce && !et && (i_exc_req || o_fp_trap || o_cp_trap)
		|=> o_error_mode) else $error("no halt");
	priv_trap_a: assert property (o_priv_trap == ((i_rd_en || i_wr_en) && !s))
		else $error("privilege trap");
	sup_out_a: assert property (o_supervisor == s)
		else $error("supervisor output");
	irq_gate_a: assert property (o_irq_take |-> et && (i_irq_level == PST_NMI_LEVEL
		|| i_irq_level > o_state[11:8])) else $error("interrupt level");
	fp_gate_a: assert property (i_fp_instr && !o_error_mode |-> o_fp_trap == !o_state[12])
		else $error("float trap");
	cp_trap_a: assert property (o_cp_trap == i_cp_instr)
		else $error("cp trap");
	ro_bits_a: assert property (o_state[31:14] == {PST_IMPL_DEF, PST_VER_DEF, o_state[23:20],
		6'h00} && o_state[4:3] == 2'h0) else $error("fixed bits");
endmodule : pst_monitor
bind pst_state_reg pst_monitor pst_monitor_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
	.i_exc_req(i_exc_req), .i_fp_instr(i_fp_instr), .i_cp_instr(i_cp_instr),
	.i_irq_level(i_irq_level), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en), .o_state(o_state),
	.o_supervisor(o_supervisor), .o_priv_trap(o_priv_trap), .o_trap_take(o_trap_take),
	.o_irq_take(o_irq_take), .o_fp_trap(o_fp_trap), .o_cp_trap(o_cp_trap),
	.o_error_mode(o_error_mode));
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pst_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic ce = 1'b1;
	logic cc, exc, fp, cp, sv, rs, rt, rd, wr, v;
	pst_op_t op;
	logic [31:0] a, b, lr, wd, rdat, st, m, r;
	logic [32:0] s33, e;
	logic [3:0] irq;
	logic [32:0] q[$];
	int n_errors = 0;
	int n_checks = 0;
	int seed = 16296;
	always #5 i_clk = ~i_clk;
	pst_state_reg pst_state_reg_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_cc_en(cc),
		.i_op(op), .i_op_a(a), .i_op_b(b), .i_logic_res(lr), .i_exc_req(exc), .i_irq_level(irq),
		.i_fp_instr(fp), .i_cp_instr(cp), .i_save(sv), .i_restore(rs), .i_rett(rt), .i_rd_en(rd),
		.i_wr_en(wr), .i_wr_data(wd), .o_rd_data(rdat), .o_state(st), .o_supervisor(),
		.o_trap_take(), .o_irq_take(), .o_fp_trap(), .o_cp_trap(), .o_priv_trap(),
		.o_error_mode());
	task cmp(input string nm, input logic [31:0] ex, input logic [31:0] g);
		n_checks++;
		if (g !== ex) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, ex, g);
		end
	endtask : cmp
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// Expected word queued before the edge that acts on it
	task tick(input logic k, input logic [31:0] x);
		q.push_back({k, x});
		@(posedge i_clk);
		#1;
		{cc, exc, fp, cp, sv, rs, rt, rd, wr} = '0;
	endtask : tick
	task trap_m;
		m = {m[31:8], 1'b1, m[7], 1'b0, m[4:3], m[2:0] - 3'h1};
	endtask : trap_m
	always @(posedge i_clk) begin
		if (q.size() > 0) begin
			#3;
			e = q.pop_front();
			if (e[32]) cmp("read", e[31:0], rdat);
			else cmp("state", e[31:0], st);
		end
	end
	initial begin
		repeat (1000) @(posedge i_clk);
		n_errors++;
		test_done();
	end
	initial begin
		{cc, exc, fp, cp, sv, rs, rt, rd, wr} = '0;
		{a, b, lr, wd, irq} = '0;
		op = PST_OP_ADD;
		repeat (5) @(posedge i_clk);
		#1;
		i_nrst = 1'b1;
		m = 32'hA5000080;
		rd = 1'b1;
		tick(1'b1, m);
		ce = 1'b0;
		exc = 1'b1;
		wr = 1'b1;
		wd = 32'hFFFFFFFF;
		tick(1'b0, m);
		ce = 1'b1;
		for (int i = 0; i < 9; i++) begin
			op = (i % 3 == 2) ? PST_OP_LOGIC : pst_op_t'(i % 3);
			a = $random(seed);
			b = (i == 4) ? a : $random(seed);
			lr = (i == 5) ? 32'h0 : $random(seed);
			s33 = (op == PST_OP_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
			r = (op == PST_OP_LOGIC) ? lr : s33[31:0];
			v = (op == PST_OP_ADD) ? (a[31] == b[31] && r[31] != a[31]) :
				(op == PST_OP_SUB) ? (a[31] != b[31] && r[31] != a[31]) : 1'b0;
			m[23:20] = {r[31], r == 32'h0, v, (op != PST_OP_LOGIC) && s33[32]};
			cc = 1'b1;
			tick(1'b0, m);
		end
		$display("flags test done");
		wr = 1'b1;
		wd = 32'hFFFFFFFF;
		rd = 1'b1;
		tick(1'b1, m);
		m = 32'hA5F03FE7;
		tick(1'b0, m);
		exc = 1'b1;
		trap_m();
		tick(1'b0, m);
		rt = 1'b1;
		m = 32'hA5F03FE7;
		tick(1'b0, m);
		rs = 1'b1;
		m[2:0] = 3'h0;
		tick(1'b0, m);
		sv = 1'b1;
		m[2:0] = 3'h7;
		tick(1'b0, m);
		fp = 1'b1;
		tick(1'b0, m);
		cp = 1'b1;
		trap_m();
		tick(1'b0, m);
		irq = 4'hF;
		tick(1'b0, m);
		rt = 1'b1;
		irq = 4'hE;
		m = 32'hA5F03FE7;
		tick(1'b0, m);
		irq = 4'hF;
		trap_m();
		tick(1'b0, m);
		$display("trap test done");
		wr = 1'b1;
		wd = 32'h000005A1;
		irq = 4'h0;
		m = 32'hA50005A1;
		tick(1'b0, m);
		irq = 4'h5;
		tick(1'b0, m);
		irq = 4'h6;
		trap_m();
		tick(1'b0, m);
		irq = 4'h0;
		wr = 1'b1;
		wd = 32'h00000021;
		m = 32'hA5000021;
		tick(1'b0, m);
		wr = 1'b1;
		wd = 32'hFFFFFFFF;
		trap_m();
		tick(1'b0, m);
		fp = 1'b1;
		tick(1'b0, m);
		wr = 1'b1;
		tick(1'b0, m);
		$display("mode test done");
		i_nrst = 1'b0;
		@(posedge i_clk);
		#1;
		i_nrst = 1'b1;
		tick(1'b0, 32'hA5000080);
		#5;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
